//--- cpuc_pkg.sv
// Constants, state types and field layout for the camera parameter update controller.
// Assumes one 40 MHz core clock; bit positions below count from the LSB (register bit 0 = MSB).
// How it works
// [RULE1] Two packet-size words: enable, set-max, size limit
// [RULE2] Separate limits per speed, each with presence flag
// [RULE3] Set-to-maximum loads largest supported size
// [RULE4] Host enables with flag and larger size
// [RULE5] Stored size limit forced to four-byte multiple
// [RULE6] Stored size limit never below speed minimum
// [RULE7] Both size settings saved in user sets
// [RULE8] New limit applies only after format-mode write
// [RULE9] Timing field: 0 standard, 2 quick change
// [RULE10] Window flag bit opens, clearing closes update
// [RULE11] Read-only presence bit in timing and info
// [RULE12] Quick mode aborts integration, keeps running transfer
// [RULE13] Host: set mode, open window, finish in 10s
// [RULE14] Window-open write restarts ten second time-out
// [RULE15] Time-out clears window and applies pending changes
// [RULE16] Open window holds writes until flag cleared; code holds list pairs whenever the timing field is not 0, standard commits each at once
// [RULE17] Info register reports list capacity in bytes
// [RULE18] Address/data pairs written once, each processed
// [RULE19] Pairs apply singly or after whole list
// [RULE20] List buffer shared with general data buffer
// [RULE21] Only a subset of registers accept list writes
`default_nettype none
package cpuc_pkg;
  localparam logic [31:0] ADDR_LIMIT_LOW  = 32'hF1000560;
  localparam logic [31:0] ADDR_LIMIT_HIGH = 32'hF1000564;
  localparam logic [31:0] ADDR_TIMING     = 32'hF1000570;
  localparam logic [31:0] ADDR_LIST_INFO  = 32'hF1100000;
  localparam logic [31:0] ADDR_LIST_BASE  = 32'hF1101000;

  localparam int PRESENCE_BIT = 31;
  localparam int ENABLE_BIT   = 25;
  localparam int TO_MAX_BIT   = 24;
  localparam int WINDOW_BIT   = 25;

  localparam logic [7:0] TIMING_STANDARD = 8'h00;
  localparam logic [7:0] TIMING_QUICK    = 8'h02;

  localparam logic [15:0] SIZE_MIN_LOW   = 16'h0800;
  localparam logic [15:0] SIZE_MIN_HIGH  = 16'h1000;
  localparam logic [15:0] SIZE_MAX_LOW   = 16'h1000;
  localparam logic [15:0] SIZE_MAX_HIGH  = 16'h2AF8;
  localparam logic [15:0] SIZE_ALIGN_MSK = 16'hFFFC;

  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned TMO_TIME_S   = 10;
  localparam int unsigned TMO_CYCLES   = TMO_TIME_S * CLK_HZ;

  localparam int LIST_AW    = 10;
  localparam int LIST_DEPTH = 1024;

  typedef enum logic [4:0] {
    P_IDLE = 5'h01,
    P_RA   = 5'h02,
    P_RD   = 5'h04,
    P_EX   = 5'h08,
    P_END  = 5'h10
  } cpuc_proc_e;

  typedef struct packed {
    logic [1:0]          iso_en;
    logic [1:0][15:0]    iso_lim;
    logic [1:0][15:0]    act_lim;
    logic [7:0]          sel;
    logic                win;
    logic                tmo_run;
    logic [31:0]         tmo_cnt;
    cpuc_proc_e          proc;
    logic [LIST_AW-1:0]  rem;
    logic [LIST_AW-2:0]  pidx;
    logic [31:0]         paddr;
    logic                rsp_v;
    logic                rsp_err;
    logic                rsp_mem;
    logic [31:0]         rsp_d;
    logic                pwr_v;
    logic [31:0]         pwr_a;
    logic [31:0]         pwr_d;
    logic                commit;
    logic                abort;
  } cpuc_state_s;
endpackage
`default_nettype wire

//--- cpuc_mem_if.sv
// Port bundle between the controller and its list buffer memory.
// Assumes both ends sit on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface cpuc_mem_if;
  logic                        we;
  logic [cpuc_pkg::LIST_AW-1:0] waddr;
  logic [31:0]                 wdata;
  logic                        re;
  logic [cpuc_pkg::LIST_AW-1:0] raddr;
  logic [31:0]                 rdata;
  modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

//--- cpuc_list_mem.sv
// Parameter list buffer: one write port, one read port, registered read data.
// Assumes synchronous reset copy from the controller; contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module cpuc_list_mem #(
  parameter int DEPTH = cpuc_pkg::LIST_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  cpuc_mem_if.mem  port
);
  // Storage is the same array the general data buffer would use; never both at once
  logic [31:0] mem_q [DEPTH]; // RULE20
  logic [31:0] rd_r;

  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_q[port.waddr] <= port.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= 32'h0000_0000;
    end else if (port.re) begin
      rd_r <= mem_q[port.raddr];
    end
  end

  assign port.rdata = rd_r;
endmodule
`default_nettype wire

//--- cpuc_top.sv
// Packet-size limits, update timing window and parameter list engine.
// Assumes a quadlet request port from the link layer on CORE_CLK.
`timescale 1ns/1ps
`default_nettype none
module cpuc_top #(
  parameter int unsigned  TMO_CYC      = cpuc_pkg::TMO_CYCLES,
  parameter int           DEPTH        = cpuc_pkg::LIST_DEPTH,
  parameter logic         PRES_LOW     = 1'b1,
  parameter logic         PRES_HIGH    = 1'b1,
  parameter logic [31:0]  TGT_BASE     = 32'hF0F00000,
  parameter logic [31:0]  TGT_MASK     = 32'hFFFF0000
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_LAST,
  input  wire logic [31:0] REQ_ADDR,
  input  wire logic [31:0] REQ_WDATA,
  output logic             RSP_VALID,
  output logic             RSP_ERR,
  output logic [31:0]      RSP_RDATA,
  input  wire logic        FMT_MODE_WRITE,
  output logic [15:0]      PKT_CEIL_LOW,
  output logic [15:0]      PKT_CEIL_HIGH,
  output logic [33:0]      USERSET_IMAGE,
  input  wire logic        USERSET_LOAD,
  input  wire logic [33:0] USERSET_DATA,
  output logic             PARAM_WR_VALID,
  output logic [31:0]      PARAM_WR_ADDR,
  output logic [31:0]      PARAM_WR_DATA,
  output logic             PARAM_COMMIT,
  output logic             ABORT_INTEGRATION,
  output logic             LIST_BUSY
);
  localparam logic [31:0] LIST_END = cpuc_pkg::ADDR_LIST_BASE + 32'(DEPTH * 4);
  localparam logic [15:0] LIST_CAP = 16'(DEPTH * 4);

  logic [1:0]           rst_sync;
  logic                 rst_n;
  cpuc_pkg::cpuc_state_s s_r, s_nxt;
  cpuc_mem_if           mif ();

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  cpuc_list_mem #(.DEPTH(DEPTH)) u_mem (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .port  (mif.mem)
  );

  function automatic logic [15:0] fit_size(input logic [15:0] v, input logic [15:0] mn);
    logic [15:0] a;
    a = v & cpuc_pkg::SIZE_ALIGN_MSK; // RULE5
    return (a < mn) ? mn : a; // RULE6
  endfunction

  function automatic logic is_own(input logic [31:0] a);
    return (a == cpuc_pkg::ADDR_LIMIT_LOW) || (a == cpuc_pkg::ADDR_LIMIT_HIGH) ||
           (a == cpuc_pkg::ADDR_TIMING) || (a == cpuc_pkg::ADDR_LIST_INFO);
  endfunction

  // Write one of the block's own registers; shared by bus and list engine
  function automatic cpuc_pkg::cpuc_state_s reg_wr(input cpuc_pkg::cpuc_state_s t,
                                                   input logic [31:0] a,
                                                   input logic [31:0] d);
    int i;
    i = (a == cpuc_pkg::ADDR_LIMIT_HIGH) ? 1 : 0;
    if ((a == cpuc_pkg::ADDR_LIMIT_LOW) || (a == cpuc_pkg::ADDR_LIMIT_HIGH)) begin
      t.iso_en[i] = d[cpuc_pkg::ENABLE_BIT]; // RULE1
      if (d[cpuc_pkg::TO_MAX_BIT]) begin
        t.iso_lim[i] = (i == 1) ? cpuc_pkg::SIZE_MAX_HIGH : cpuc_pkg::SIZE_MAX_LOW; // RULE3
      end else begin
        t.iso_lim[i] = fit_size(d[15:0], (i == 1) ? cpuc_pkg::SIZE_MIN_HIGH
                                                  : cpuc_pkg::SIZE_MIN_LOW); // RULE2
      end
    end else if (a == cpuc_pkg::ADDR_TIMING) begin
      t.sel = d[7:0]; // RULE9
      if (t.win && !d[cpuc_pkg::WINDOW_BIT]) begin
        t.commit  = 1'b1; // RULE16
        t.tmo_run = 1'b0;
      end
      if (d[cpuc_pkg::WINDOW_BIT]) begin
        t.tmo_cnt = 32'h0000_0000; // RULE14
        t.tmo_run = 1'b1;
      end
      t.win = d[cpuc_pkg::WINDOW_BIT]; // RULE10
    end
    return t;
  endfunction

  logic        req_take;
  logic        in_list;
  logic [31:0] list_off;

  assign REQ_READY = (s_r.proc == cpuc_pkg::P_IDLE);
  assign req_take  = REQ_VALID && REQ_READY;
  assign in_list   = (REQ_ADDR >= cpuc_pkg::ADDR_LIST_BASE) && (REQ_ADDR < LIST_END);
  assign list_off  = REQ_ADDR - cpuc_pkg::ADDR_LIST_BASE;

  always_comb begin
    s_nxt     = s_r;
    s_nxt.rsp_v   = 1'b0;
    s_nxt.rsp_err = 1'b0;
    s_nxt.rsp_mem = 1'b0;
    s_nxt.pwr_v   = 1'b0;
    s_nxt.commit  = 1'b0;
    s_nxt.abort   = 1'b0;
    mif.we    = 1'b0;
    mif.waddr = list_off[cpuc_pkg::LIST_AW+1:2];
    mif.wdata = REQ_WDATA;
    mif.re    = 1'b0;
    mif.raddr = list_off[cpuc_pkg::LIST_AW+1:2];

    // Time-out first, so a window-open write in the same cycle restarts it
    if (s_r.tmo_run) begin
      if (s_r.tmo_cnt == TMO_CYC - 32'd1) begin
        s_nxt.tmo_run = 1'b0;
        s_nxt.win     = 1'b0; // RULE15
        s_nxt.commit  = 1'b1; // RULE15
      end else begin
        s_nxt.tmo_cnt = s_r.tmo_cnt + 32'd1;
      end
    end

    if (FMT_MODE_WRITE) begin
      s_nxt.act_lim[0] = s_r.iso_en[0] ? s_r.iso_lim[0] : cpuc_pkg::SIZE_MIN_LOW; // RULE8
      s_nxt.act_lim[1] = s_r.iso_en[1] ? s_r.iso_lim[1] : cpuc_pkg::SIZE_MIN_HIGH; // RULE8
    end

    if (USERSET_LOAD) begin
      {s_nxt.iso_en[1], s_nxt.iso_lim[1], s_nxt.iso_en[0], s_nxt.iso_lim[0]} = USERSET_DATA; // RULE7
    end

    if (req_take) begin
      s_nxt.rsp_v = 1'b1;
      if (REQ_WRITE) begin
        if (in_list) begin
          mif.we = 1'b1; // RULE18
          if (REQ_LAST && (list_off[cpuc_pkg::LIST_AW+1:3] != '0)) begin
            s_nxt.rem  = {1'b0, list_off[cpuc_pkg::LIST_AW+1:3]} +
                         cpuc_pkg::LIST_AW'(list_off[2]);
            s_nxt.pidx = '0;
            s_nxt.proc = cpuc_pkg::P_RA;
          end else if (REQ_LAST && list_off[2]) begin
            s_nxt.rem  = cpuc_pkg::LIST_AW'(1);
            s_nxt.pidx = '0;
            s_nxt.proc = cpuc_pkg::P_RA;
          end
        end else if (is_own(REQ_ADDR)) begin
          s_nxt = reg_wr(s_nxt, REQ_ADDR, REQ_WDATA);
        end else begin
          s_nxt.rsp_err = 1'b1;
        end
      end else begin
        s_nxt.rsp_d = 32'h0000_0000;
        unique case (1'b1)
          (REQ_ADDR == cpuc_pkg::ADDR_LIMIT_LOW): begin
            s_nxt.rsp_d = {PRES_LOW, 5'h00, s_r.iso_en[0], 9'h000, s_r.iso_lim[0]}; // RULE2
          end
          (REQ_ADDR == cpuc_pkg::ADDR_LIMIT_HIGH): begin
            s_nxt.rsp_d = {PRES_HIGH, 5'h00, s_r.iso_en[1], 9'h000, s_r.iso_lim[1]}; // RULE2
          end
          (REQ_ADDR == cpuc_pkg::ADDR_TIMING): begin
            s_nxt.rsp_d = {1'b1, 5'h00, s_r.win, 17'h00000, s_r.sel}; // RULE11
          end
          (REQ_ADDR == cpuc_pkg::ADDR_LIST_INFO): begin
            s_nxt.rsp_d = {1'b1, 15'h0000, LIST_CAP}; // RULE17
          end
          in_list: begin
            mif.re        = 1'b1;
            s_nxt.rsp_mem = 1'b1;
          end
          default: begin
            s_nxt.rsp_err = 1'b1;
          end
        endcase
      end
    end

    case (s_r.proc)
      cpuc_pkg::P_IDLE: begin
      end
      cpuc_pkg::P_RA: begin
        mif.re     = 1'b1;
        mif.raddr  = {s_r.pidx, 1'b0};
        s_nxt.proc = cpuc_pkg::P_RD;
      end
      cpuc_pkg::P_RD: begin
        mif.re      = 1'b1;
        mif.raddr   = {s_r.pidx, 1'b1};
        s_nxt.paddr = mif.rdata;
        s_nxt.proc  = cpuc_pkg::P_EX;
      end
      cpuc_pkg::P_EX: begin
        if (is_own(s_r.paddr)) begin
          s_nxt = reg_wr(s_nxt, s_r.paddr, mif.rdata); // RULE18
        end else if ((s_r.paddr & TGT_MASK) == TGT_BASE) begin // RULE21
          s_nxt.pwr_v = 1'b1;
          s_nxt.pwr_a = s_r.paddr;
          s_nxt.pwr_d = mif.rdata;
          if (s_r.sel == cpuc_pkg::TIMING_STANDARD) begin
            s_nxt.commit = 1'b1; // RULE19
          end
        end
        s_nxt.rem  = s_r.rem - cpuc_pkg::LIST_AW'(1);
        s_nxt.pidx = s_r.pidx + 1'b1;
        s_nxt.proc = (s_r.rem == cpuc_pkg::LIST_AW'(1)) ? cpuc_pkg::P_END : cpuc_pkg::P_RA;
      end
      cpuc_pkg::P_END: begin
        // Quick mode applies the list as a whole, unless a window still holds it
        if ((s_r.sel != cpuc_pkg::TIMING_STANDARD) && !s_r.win) begin
          s_nxt.commit = 1'b1; // RULE19
        end
        s_nxt.proc = cpuc_pkg::P_IDLE;
      end
      default: begin
        s_nxt.proc = cpuc_pkg::P_IDLE;
      end
    endcase

    // Commit in quick mode cuts exposure short; readout is left alone
    s_nxt.abort = s_nxt.commit && (s_nxt.sel == cpuc_pkg::TIMING_QUICK); // RULE12
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.iso_lim <= {cpuc_pkg::SIZE_MIN_HIGH, cpuc_pkg::SIZE_MIN_LOW};
      s_r.act_lim <= {cpuc_pkg::SIZE_MIN_HIGH, cpuc_pkg::SIZE_MIN_LOW};
      s_r.proc    <= cpuc_pkg::P_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RSP_VALID         = s_r.rsp_v;
  assign RSP_ERR           = s_r.rsp_err;
  assign RSP_RDATA         = s_r.rsp_mem ? mif.rdata : s_r.rsp_d;
  assign PKT_CEIL_LOW      = s_r.act_lim[0];
  assign PKT_CEIL_HIGH     = s_r.act_lim[1];
  assign USERSET_IMAGE     = {s_r.iso_en[1], s_r.iso_lim[1], s_r.iso_en[0], s_r.iso_lim[0]};
  assign PARAM_WR_VALID    = s_r.pwr_v;
  assign PARAM_WR_ADDR     = s_r.pwr_a;
  assign PARAM_WR_DATA     = s_r.pwr_d;
  assign PARAM_COMMIT      = s_r.commit;
  assign ABORT_INTEGRATION = s_r.abort;
  assign LIST_BUSY         = (s_r.proc != cpuc_pkg::P_IDLE);

  AST_ALIGN: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE5
    (s_r.iso_lim[0][1:0] == 2'b00) && (s_r.iso_lim[1][1:0] == 2'b00))
    else $error("size limit not four-byte aligned");
  AST_MIN: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE6
    USERSET_LOAD || $past(USERSET_LOAD) ||
    ((s_r.iso_lim[0] >= cpuc_pkg::SIZE_MIN_LOW) && (s_r.iso_lim[1] >= cpuc_pkg::SIZE_MIN_HIGH)))
    else $error("size limit below speed minimum");
  AST_TO_MAX: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE3
    req_take && REQ_WRITE && (REQ_ADDR == cpuc_pkg::ADDR_LIMIT_HIGH) &&
    REQ_WDATA[cpuc_pkg::TO_MAX_BIT] && !USERSET_LOAD |=> (s_r.iso_lim[1] == cpuc_pkg::SIZE_MAX_HIGH))
    else $error("set-to-maximum did not load maximum");
  AST_CEIL_HOLD: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE8
    !FMT_MODE_WRITE |=> $stable(PKT_CEIL_LOW) && $stable(PKT_CEIL_HIGH))
    else $error("packet ceiling moved without format-mode write");
  AST_RESTART: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE14
    req_take && REQ_WRITE && (REQ_ADDR == cpuc_pkg::ADDR_TIMING) && REQ_WDATA[cpuc_pkg::WINDOW_BIT]
    |=> s_r.tmo_run && (s_r.tmo_cnt == 32'h0000_0000) && s_r.win)
    else $error("window-open write did not restart time-out");
  AST_EXPIRE: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE15
    s_r.tmo_run && (s_r.tmo_cnt == TMO_CYC - 32'd1) && !req_take && (s_r.proc == cpuc_pkg::P_IDLE)
    |=> !s_r.win && PARAM_COMMIT)
    else $error("time-out did not close window and commit");
  AST_ABORT: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE12
    ABORT_INTEGRATION |-> PARAM_COMMIT && (s_r.sel == cpuc_pkg::TIMING_QUICK))
    else $error("abort outside quick-mode commit");
  AST_PRESENCE: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE11
    req_take && !REQ_WRITE && (REQ_ADDR == cpuc_pkg::ADDR_LIST_INFO)
    |=> RSP_VALID && RSP_RDATA[cpuc_pkg::PRESENCE_BIT] && (RSP_RDATA[15:0] == LIST_CAP))
    else $error("info read lacks presence or capacity");
  AST_STD_EACH: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE19
    PARAM_WR_VALID && ($past(s_r.sel) == cpuc_pkg::TIMING_STANDARD) |-> PARAM_COMMIT)
    else $error("standard-mode list write not applied at once");
  AST_LIST_WALK: assert property (@(posedge CORE_CLK) disable iff (!rst_n) // RULE18
    (s_r.proc == cpuc_pkg::P_RA) |=> (s_r.proc == cpuc_pkg::P_RD) ##1 (s_r.proc == cpuc_pkg::P_EX))
    else $error("list pair not walked in three cycles");

  COV_EXPIRE: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    s_r.tmo_run && (s_r.tmo_cnt == TMO_CYC - 32'd1));
  COV_LIST_DONE: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    (s_r.proc == cpuc_pkg::P_END) && (s_r.sel == cpuc_pkg::TIMING_QUICK));
  COV_TO_MAX: cover property (@(posedge CORE_CLK) disable iff (!rst_n)
    req_take && REQ_WRITE && (REQ_ADDR == cpuc_pkg::ADDR_LIMIT_LOW) && REQ_WDATA[cpuc_pkg::TO_MAX_BIT]);
endmodule
`default_nettype wire

//--- cpuc_host_model.sv
// Host-side model of the register requester for the parameter update controller.
// Assumes the caller sits at a falling edge of the core clock when it calls a task.
`timescale 1ns/1ps
`default_nettype none
module cpuc_host_model (
  input  wire logic        core_clk,
  input  wire logic        req_ready,
  input  wire logic        rsp_valid,
  input  wire logic        rsp_err,
  input  wire logic [31:0] rsp_rdata,
  output logic             req_valid,
  output logic             req_write,
  output logic             req_last,
  output logic [31:0]      req_addr,
  output logic [31:0]      req_wdata
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_last  = 1'b0;
    req_addr  = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
  end

  // One quadlet; request stays up until the edge that takes it, answer read at the falling edge after it.
  // A list is sent as one unbroken burst, and never mixed with general data.
  task automatic xfer(input logic w, input logic l, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] st);
    req_valid = 1'b1;
    req_write = w;
    req_last  = l;
    req_addr  = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
    @(negedge core_clk);
    q  = rsp_rdata;
    st = {rsp_valid, rsp_err};
  endtask

  // Released address and data lines toggle each cycle so stale values never look valid
  task automatic idle(input int n);
    req_valid = 1'b0;
    req_last  = 1'b0;
    for (int i = 0; i < n; i++) begin
      req_addr  = ~req_addr;
      req_wdata = ~req_wdata;
      @(negedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- camera_param_update_ctrl_tb.sv
// Self-checking bench for the parameter update controller top.
// Assumes the package, memory, top and host model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module camera_param_update_ctrl_tb;
  localparam int TMO = 50;
  logic        core_clk;
  logic        rst_b;
  logic        req_valid, req_ready, req_write, req_last;
  logic [31:0] req_addr, req_wdata, rsp_rdata, param_wr_addr, param_wr_data;
  logic        rsp_valid, rsp_err, fmt_mode_write, userset_load;
  logic [15:0] ceil_low, ceil_high;
  logic [33:0] userset_image, userset_data;
  logic        param_wr_valid, param_commit, abort_int, list_busy;
  int          n_mismatch, cmp_count, n_commit, n_abort;
  logic [31:0] wa[$];
  logic [31:0] wd[$];
  logic [31:0] q;
  logic [1:0]  st;

  cpuc_top #(.TMO_CYC(TMO)) dut_u (
    .CORE_CLK(core_clk), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_WRITE(req_write), .REQ_LAST(req_last), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .RSP_VALID(rsp_valid), .RSP_ERR(rsp_err), .RSP_RDATA(rsp_rdata),
    .FMT_MODE_WRITE(fmt_mode_write), .PKT_CEIL_LOW(ceil_low), .PKT_CEIL_HIGH(ceil_high),
    .USERSET_IMAGE(userset_image), .USERSET_LOAD(userset_load), .USERSET_DATA(userset_data),
    .PARAM_WR_VALID(param_wr_valid), .PARAM_WR_ADDR(param_wr_addr),
    .PARAM_WR_DATA(param_wr_data), .PARAM_COMMIT(param_commit),
    .ABORT_INTEGRATION(abort_int), .LIST_BUSY(list_busy));

  cpuc_host_model u_host (
    .core_clk(core_clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
    .rsp_rdata(rsp_rdata), .req_valid(req_valid), .req_write(req_write),
    .req_last(req_last), .req_addr(req_addr), .req_wdata(req_wdata));

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (param_wr_valid === 1'b1) begin
      wa.push_back(param_wr_addr);
      wd.push_back(param_wr_data);
    end
    if (param_commit === 1'b1) n_commit++;
    if (abort_int === 1'b1) n_abort++;
  end

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, 1'b0, a, d, q, st);
    u_host.idle(1);
  endtask

  task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] exp);
    u_host.xfer(1'b0, 1'b0, a, 32'h0000_0000, q, st);
    u_host.idle(1);
    chk({nm, " rsp"}, {32'h0, st}, {32'h0, 2'b10});
    chk(nm, {2'b00, q}, {2'b00, exp});
  endtask

  // Sends a list as one burst and waits, bounded, for the engine to finish
  task automatic send_list(input logic [31:0] w[$]);
    int k;
    for (int i = 0; i < w.size(); i++) begin
      u_host.xfer(1'b1, i == w.size() - 1, cpuc_pkg::ADDR_LIST_BASE + 32'(4 * i), w[i], q, st);
    end
    u_host.idle(1);
    chk("ready while busy", {33'h0, req_ready}, 34'h0);
    k = 0;
    while (list_busy !== 1'b0 && k < 200) begin
      @(negedge core_clk);
      k++;
    end
    chk("list done", {33'h0, k < 200}, 34'h1);
  endtask

  task automatic t_reset();
    chk("ceil low", {18'h0, ceil_low}, {18'h0, 16'h0800});
    chk("ceil high", {18'h0, ceil_high}, {18'h0, 16'h1000});
    rd("info", cpuc_pkg::ADDR_LIST_INFO, 32'h8000_1000);
    wr(cpuc_pkg::ADDR_LIST_INFO, 32'h0000_0000);
    rd("info ro", cpuc_pkg::ADDR_LIST_INFO, 32'h8000_1000);
    rd("timing", cpuc_pkg::ADDR_TIMING, 32'h8000_0000);
    rd("lim low", cpuc_pkg::ADDR_LIMIT_LOW, 32'h8000_0800);
    rd("lim high", cpuc_pkg::ADDR_LIMIT_HIGH, 32'h8000_1000);
    u_host.xfer(1'b0, 1'b0, 32'hF100_0568, 0, q, st);
    u_host.idle(1);
    chk("unmapped", {32'h0, st}, {32'h0, 2'b11});
    $display("test reset done");
  endtask

  task automatic t_size();
    wr(cpuc_pkg::ADDR_LIMIT_LOW, 32'h0200_0123);
    rd("clamp", cpuc_pkg::ADDR_LIMIT_LOW, 32'h8200_0800);
    wr(cpuc_pkg::ADDR_LIMIT_LOW, 32'h0200_0A03);
    rd("align", cpuc_pkg::ADDR_LIMIT_LOW, 32'h8200_0A00);
    wr(cpuc_pkg::ADDR_LIMIT_HIGH, 32'h0300_0000);
    rd("to max", cpuc_pkg::ADDR_LIMIT_HIGH, 32'h8200_2AF8);
    chk("ceil held", {18'h0, ceil_low}, {18'h0, 16'h0800});
    fmt_mode_write = 1'b1;
    @(negedge core_clk);
    fmt_mode_write = 1'b0;
    @(negedge core_clk);
    chk("ceil low new", {18'h0, ceil_low}, {18'h0, 16'h0A00});
    chk("ceil high new", {18'h0, ceil_high}, {18'h0, 16'h2AF8});
    chk("userset", userset_image, {1'b1, 16'h2AF8, 1'b1, 16'h0A00});
    userset_data = {1'b0, 16'h1234, 1'b1, 16'h0900};
    userset_load = 1'b1;
    @(negedge core_clk);
    userset_load = 1'b0;
    rd("load high", cpuc_pkg::ADDR_LIMIT_HIGH, 32'h8000_1234);
    rd("load low", cpuc_pkg::ADDR_LIMIT_LOW, 32'h8200_0900);
    $display("test size done");
  endtask

  task automatic t_timeout();
    int c;
    int a;
    wr(cpuc_pkg::ADDR_TIMING, 32'h0000_0002);
    wr(cpuc_pkg::ADDR_TIMING, 32'h0200_0002);
    rd("window open", cpuc_pkg::ADDR_TIMING, 32'h8200_0002);
    repeat (25) @(negedge core_clk);
    c = n_commit;
    a = n_abort;
    wr(cpuc_pkg::ADDR_TIMING, 32'h0200_0002);
    repeat (44) @(negedge core_clk);
    chk("no early commit", 34'(n_commit - c), 34'h0);
    repeat (12) @(negedge core_clk);
    chk("timeout commit", 34'(n_commit - c), 34'h1);
    chk("timeout abort", 34'(n_abort - a), 34'h1);
    rd("auto close", cpuc_pkg::ADDR_TIMING, 32'h8000_0002);
    wr(cpuc_pkg::ADDR_TIMING, 32'h0200_0002);
    c = n_commit;
    wr(cpuc_pkg::ADDR_TIMING, 32'h0000_0002);
    repeat (2) @(negedge core_clk);
    chk("close commit", 34'(n_commit - c), 34'h1);
    $display("test timeout done");
  endtask

  task automatic t_list_std();
    int j;
    int c;
    int a;
    logic [31:0] ea[$];
    logic [31:0] ed[$];
    ea = '{32'hF0F0_0608, 32'hF0F0_080C};
    ed = '{32'hE000_0000, 32'h8000_0100};
    wr(cpuc_pkg::ADDR_TIMING, 32'h0000_0000);
    wa.delete();
    wd.delete();
    c = n_commit;
    a = n_abort;
    send_list('{32'hF0F0_0608, 32'hE000_0000, 32'h1234_5678, 32'h0000_0001,
                cpuc_pkg::ADDR_LIMIT_LOW, 32'h0200_0C00, 32'hF0F0_080C, 32'h8000_0100});
    chk("std commits", 34'(n_commit - c), 34'h2);
    chk("std abort", 34'(n_abort - a), 34'h0);
    j = 0;
    foreach (wa[i]) begin
      if (wa[i] !== cpuc_pkg::ADDR_LIMIT_LOW) begin
        chk("list addr", {2'b00, wa[i]}, {2'b00, ea[j]});
        chk("list data", {2'b00, wd[i]}, {2'b00, ed[j]});
        j++;
      end
    end
    chk("list count", 34'(j), 34'h2);
    rd("list own reg", cpuc_pkg::ADDR_LIMIT_LOW, 32'h8200_0C00);
    $display("test list standard done");
  endtask

  task automatic t_list_quick();
    int c;
    int a;
    wr(cpuc_pkg::ADDR_TIMING, 32'h0000_0002);
    wa.delete();
    c = n_commit;
    a = n_abort;
    send_list('{32'hF0F0_0820, 32'h8000_0080, 32'hF0F0_080C, 32'h8000_0100, 32'hF0F0_0604});
    repeat (2) @(negedge core_clk);
    chk("quick writes", 34'(wa.size()), 34'h2);
    chk("quick commit", 34'(n_commit - c), 34'h1);
    chk("quick abort", 34'(n_abort - a), 34'h1);
    rd("list readback", cpuc_pkg::ADDR_LIST_BASE + 32'h4, 32'h8000_0080);
    $display("test list quick done");
  endtask

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    n_commit = 0;
    n_abort = 0;
    rst_b = 1'b0;
    fmt_mode_write = 1'b0;
    userset_load = 1'b0;
    userset_data = 34'h0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_size();
    t_timeout();
    t_list_std();
    t_list_quick();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
